// *** hw/pdio_pkg.sv ***
/*
  Constants shared by the port block: register offsets, field positions,
  reset values and filter timing.
  Assumes a 25 MHz ref_clk and a 32-bit Avalon-MM register bus.
*/
package pdio_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int NBID = 7;
  localparam int EDGE_W = 12;
  localparam int FCNT_W = 3;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_PORT0 = 8'h00;
  localparam logic [7:0] OFF_PORT1 = 8'h04;
  localparam logic [7:0] PORT_STEP = 8'h04;
  localparam logic [7:0] OFF_PAIR67 = 8'h24;
  localparam logic [7:0] OFF_PAIR45 = 8'h28;
  localparam logic [7:0] OFF_BITPORT = 8'h2c;
  localparam logic [7:0] OFF_BPMODE = 8'h30;
  localparam logic [7:0] OFF_DIR = 8'h34;
  localparam logic [7:0] OFF_PULL = 8'h38;
  localparam logic [7:0] OFF_EDGE = 8'h3c;
  localparam logic [7:0] OFF_STAT = 8'h40;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int DIR_P3 = 0;
  localparam int DIR_P6 = 4;
  localparam int DIR_P2 = 8;
  localparam int DIR_P4 = 9;
  localparam int DIR_P5 = 10;
  localparam int DIR_P7 = 11;
  localparam int DIR_P8 = 12;
  localparam int IDX_P4 = 2;
  localparam int IDX_P5 = 3;
  localparam int IDX_P6 = 4;
  localparam int IDX_P7 = 5;
  localparam int KEY_LSB = 16;
  localparam int ST_SUBOSC = 5;

  // ****************************************
  // Reset values and build options
  // ****************************************
  localparam logic [12:0] DIR_RST = 13'h0000;
  localparam logic [6:0] PULL_RST = 7'h00;
  localparam logic [3:0] LAT_RST = 4'hf;
  localparam logic [7:0] BPL_RST = 8'h00;
  localparam logic [1:0] BPM_RST = 2'h0;
  localparam logic [1:0] EDGE_RST = 2'h3;
  localparam logic [4:0] FLAG_RST = 5'h00;
  localparam logic [7:0] OD_PULL_OPT = 8'hff;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 40;
  localparam int FILT_NS = 200;
  localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
endpackage

// *** hw/pdio_filt.sv ***
/*
  Noise filter for one input: the output follows the input only after the
  input has differed from it for FILT_CYC consecutive enabled clocks.
  Assumes the input is synchronous to ref_clk.
*/
`timescale 1ns/1ns
module pdio_filt (
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  // Levels
  input wire logic din,
  output logic q
);
  import pdio_pkg::*;

  logic q_ff;
  logic nxt_q;
  logic [FCNT_W-1:0] cnt_ff;
  logic [FCNT_W-1:0] nxt_cnt;

  // Pulses shorter than the window never reach the edge detectors.
  always_comb
  begin
    nxt_q = q_ff;
    nxt_cnt = '0;
    if (din != q_ff)
    begin
      if (cnt_ff == FCNT_W'(FILT_CYC - 1))
        nxt_q = din;
      else
        nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q_ff <= 1'b0;
      cnt_ff <= '0;
    end
    else if (ce)
    begin
      q_ff <= nxt_q;
      cnt_ff <= nxt_cnt;
    end
  end

  assign q = q_ff;
endmodule // pdio_filt

// *** hw/pdio_edge.sv ***
/*
  Edge detector for the event inputs: one previous-level flop per bit and
  combinational rise and fall strobes, valid while ce is high.
  Assumes inputs synchronous to ref_clk.
*/
`timescale 1ns/1ns
module pdio_edge (
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  // Levels and strobes
  input wire logic [pdio_pkg::EDGE_W-1:0] d,
  output logic [pdio_pkg::EDGE_W-1:0] rise,
  output logic [pdio_pkg::EDGE_W-1:0] fall
);
  import pdio_pkg::*;

  logic [EDGE_W-1:0] prev_ff;
  logic [EDGE_W-1:0] nxt_prev;

  always_comb
  begin
    nxt_prev = d;
    rise = d & ~prev_ff;
    fall = ~d & prev_ff;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      prev_ff <= '0;
    else if (ce)
      prev_ff <= nxt_prev;
  end
endmodule // pdio_edge

// *** hw/pdio_top.sv ***
/*
  Port block: input ports 0 and 1, bidirectional ports 2,3,6,7,8,
  open-drain ports 4 and 5, the eight-bit bit port, pull-up controls and
  the edge-detecting event inputs, behind an Avalon-MM slave.
  Assumes all pin inputs are synchronous to ref_clk and that ce stays high
  while a bus request is outstanding.
*/
`timescale 1ns/1ns
// Summary of operation
// - Ports 0 and 1 always read back the pin levels, whatever the shared pin does.
// - Ports 3 and 6 have a direction bit for each pin.
// - Ports 2, 7, 8 and the open-drain ports 4 and 5 switch direction as a whole nibble.
// - Ports 6 and 7 read and write together as one byte through a pair register.
// - Ports 4 and 5 read and write together as one byte through a pair register.
// - The eight bit-port lines are written one by one and each half can carry segment data.
// - One setting turns the pull-ups of port 0 bits 1 to 3 on or off; bit 0 has none.
// - Ports 1, 2, 3, 6, 7 and 8 each have one pull-up setting for all four bits.
// - After reset all ports are inputs and the open-drain ports release their pins.
// - Port 0 bit 0 raises an interrupt request on both edges.
// - Port 1 bits 0 and 1 raise interrupts on a chosen edge, bit 0 clocked, bit 1 direct.
// - A rising edge on port 1 bit 2 sets a testable flag with no interrupt.
// - A falling edge on any of the eight key-return inputs sets one testable flag.
// - Port 1 bits 0 to 2 are noise filtered before their edges are detected.
// - The subsystem oscillator input reads as a one-bit test input.
// - The open-drain pull-ups are a fixed build option, not a software setting.
module pdio_top (
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [pdio_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [pdio_pkg::DW-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [pdio_pkg::DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Input-only pins
  input wire logic [3:0] port0_in,
  input wire logic [3:0] port1_in,
  input wire logic sub_osc_in,
  // Ports 2 to 8, one nibble each, port 2 lowest
  input wire logic [27:0] bid_in,
  output logic [27:0] bid_out,
  output logic [27:0] bid_oe,
  // Bit port
  input wire logic [7:0] shared_segment_outputs,
  output logic [7:0] single_bit_outputs,
  // Pull-up controls
  output logic [6:0] pull_en,
  output logic [7:0] od_pull_en,
  // Interrupt requests, one-cycle pulses
  output logic both_edge_irq,
  output logic clocked_edge_irq,
  output logic async_edge_irq
);
  import pdio_pkg::*;

  // ****************************************
  // State
  // ****************************************
  logic [3:0] lat_ff [NBID];
  logic [3:0] nxt_lat [NBID];
  logic [12:0] dir_ff, nxt_dir;
  logic [6:0] pull_ff, nxt_pull;
  logic [1:0] bpm_ff, nxt_bpm;
  logic [1:0] edg_ff, nxt_edg;
  logic [7:0] bpl_ff, nxt_bpl;
  logic [4:0] flag_ff, nxt_flag;
  logic [2:0] irq_ff, nxt_irq;
  logic clk0_ff, nxt_clk0;
  logic wait_ff, nxt_wait;
  logic [DW-1:0] rdata_ff, nxt_rdata;
  logic [27:0] bid_out_ff, nxt_bid_out;
  logic [27:0] bid_oe_ff, nxt_bid_oe;
  logic [7:0] sbo_ff, nxt_sbo;
  logic [7:0] odp_ff;

  logic [3:0] dirv [NBID];
  logic [3:0] rv [NBID];
  logic [2:0] filt;
  logic [EDGE_W-1:0] e_rise, e_fall;
  logic wr_go, clk_ev, async_ev;
  logic [15:0] wd;
  logic [15:0] dir_m;
  logic [DW-1:0] rd_val;

  function automatic logic [3:0] dir_nib(input int k, input logic [12:0] d);
    unique case (k)
      0: dir_nib = {4{d[DIR_P2]}};
      1: dir_nib = d[DIR_P3 +: 4];
      2: dir_nib = {4{d[DIR_P4]}};
      3: dir_nib = {4{d[DIR_P5]}};
      4: dir_nib = d[DIR_P6 +: 4];
      5: dir_nib = {4{d[DIR_P7]}};
      default: dir_nib = {4{d[DIR_P8]}};
    endcase
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] w,
                                          input logic [3:0] be);
    merge16 = {be[1] ? w[15:8] : old[15:8], be[0] ? w[7:0] : old[7:0]};
  endfunction

  // ****************************************
  // Per-port direction, read value and pin drive
  // ****************************************
  // Open-drain ports only ever pull low; a released bit floats or is pulled up.
  for (genvar k = 0; k < NBID; k++)
  begin : g_port
    assign dirv[k] = dir_nib(k, dir_ff);
    assign rv[k] = (dirv[k] & lat_ff[k]) | (~dirv[k] & bid_in[4*k +: 4]);
    if (k == IDX_P4 || k == IDX_P5)
    begin : g_od
      assign nxt_bid_out[4*k +: 4] = 4'h0;
      assign nxt_bid_oe[4*k +: 4] = dirv[k] & ~lat_ff[k];
    end
    else
    begin : g_pp
      assign nxt_bid_out[4*k +: 4] = lat_ff[k];
      assign nxt_bid_oe[4*k +: 4] = dirv[k];
    end
  end

  // ****************************************
  // Filters and edge detection
  // ****************************************
  for (genvar f = 0; f < 3; f++)
  begin : g_filt
    pdio_filt u_filt (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .ce(ce),
      .din(port1_in[f]),
      .q(filt[f])
    );
  end

  pdio_edge u_edge (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .ce(ce),
    .d({bid_in[KEY_LSB +: 8], filt, port0_in[0]}),
    .rise(e_rise),
    .fall(e_fall)
  );

  // ****************************************
  // Bus slave
  // ****************************************
  // One wait cycle gives the read mux a full clock before data is taken.
  assign wr_go = ce && avs_write && !wait_ff;
  assign wd = avs_writedata[15:0];
  assign dir_m = merge16({3'h0, dir_ff}, wd, avs_byteenable);

  always_comb
  begin
    rd_val = '0;
    if (avs_address == OFF_PORT0)
      rd_val[3:0] = port0_in;
    if (avs_address == OFF_PORT1)
      rd_val[3:0] = port1_in;
    for (int k = 0; k < NBID; k++)
    begin
      if (avs_address == OFF_PORT0 + 8'(PORT_STEP * (k + 2)))
        rd_val[3:0] = rv[k];
    end
    if (avs_address == OFF_PAIR67)
      rd_val[7:0] = {rv[IDX_P7], rv[IDX_P6]};
    if (avs_address == OFF_PAIR45)
      rd_val[7:0] = {rv[IDX_P5], rv[IDX_P4]};
    if (avs_address == OFF_BITPORT)
      rd_val[7:0] = bpl_ff;
    if (avs_address == OFF_BPMODE)
      rd_val[1:0] = bpm_ff;
    if (avs_address == OFF_DIR)
      rd_val[12:0] = dir_ff;
    if (avs_address == OFF_PULL)
      rd_val[6:0] = pull_ff;
    if (avs_address == OFF_EDGE)
      rd_val[1:0] = edg_ff;
    if (avs_address == OFF_STAT)
      rd_val[5:0] = {sub_osc_in, flag_ff};
  end

  always_comb
  begin
    nxt_wait = 1'b1;
    nxt_rdata = rdata_ff;
    if ((avs_read || avs_write) && wait_ff)
    begin
      nxt_wait = 1'b0;
      nxt_rdata = avs_read ? rd_val : '0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wait_ff <= 1'b1;
      rdata_ff <= '0;
    end
    else if (ce)
    begin
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************
  // Software-written registers
  // ****************************************
  always_comb
  begin
    for (int k = 0; k < NBID; k++)
    begin
      nxt_lat[k] = lat_ff[k];
      if (wr_go && avs_byteenable[0] && avs_address == OFF_PORT0 + 8'(PORT_STEP * (k + 2)))
        nxt_lat[k] = wd[3:0];
    end
    if (wr_go && avs_byteenable[0] && avs_address == OFF_PAIR67)
    begin
      nxt_lat[IDX_P6] = wd[3:0];
      nxt_lat[IDX_P7] = wd[7:4];
    end
    if (wr_go && avs_byteenable[0] && avs_address == OFF_PAIR45)
    begin
      nxt_lat[IDX_P4] = wd[3:0];
      nxt_lat[IDX_P5] = wd[7:4];
    end
    nxt_dir = dir_ff;
    nxt_pull = pull_ff;
    nxt_bpm = bpm_ff;
    nxt_edg = edg_ff;
    nxt_bpl = bpl_ff;
    if (wr_go && avs_address == OFF_DIR)
      nxt_dir = dir_m[12:0];
    if (wr_go && avs_byteenable[0] && avs_address == OFF_PULL)
      nxt_pull = wd[6:0];
    if (wr_go && avs_byteenable[0] && avs_address == OFF_BPMODE)
      nxt_bpm = wd[1:0];
    if (wr_go && avs_byteenable[0] && avs_address == OFF_EDGE)
      nxt_edg = wd[1:0];
    // Lane 1 is a bit mask, so single lines change without a read-modify-write.
    if (wr_go && avs_byteenable[1:0] == 2'h3 && avs_address == OFF_BITPORT)
      nxt_bpl = (bpl_ff & ~wd[15:8]) | (wd[7:0] & wd[15:8]);
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int k = 0; k < NBID; k++)
        lat_ff[k] <= LAT_RST;
      dir_ff <= DIR_RST;
      pull_ff <= PULL_RST;
      bpm_ff <= BPM_RST;
      edg_ff <= EDGE_RST;
      bpl_ff <= BPL_RST;
    end
    else if (ce)
    begin
      lat_ff <= nxt_lat;
      dir_ff <= nxt_dir;
      pull_ff <= nxt_pull;
      bpm_ff <= nxt_bpm;
      edg_ff <= nxt_edg;
      bpl_ff <= nxt_bpl;
    end
  end

  // ****************************************
  // Events, flags and interrupt pulses
  // ****************************************
  assign clk_ev = edg_ff[0] ? e_rise[1] : e_fall[1];
  assign async_ev = edg_ff[1] ? e_rise[2] : e_fall[2];

  // A set in the same cycle as a write-one clear wins.
  always_comb
  begin
    nxt_clk0 = clk_ev;
    nxt_irq[0] = e_rise[0] | e_fall[0];
    nxt_irq[1] = clk0_ff;
    nxt_irq[2] = async_ev;
    nxt_flag = flag_ff;
    if (wr_go && avs_byteenable[0] && avs_address == OFF_STAT)
      nxt_flag = flag_ff & ~wd[4:0];
    nxt_flag = nxt_flag | {|e_fall[11:4], e_rise[3], async_ev, clk0_ff, nxt_irq[0]};
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clk0_ff <= 1'b0;
      irq_ff <= '0;
      flag_ff <= FLAG_RST;
    end
    else if (ce)
    begin
      clk0_ff <= nxt_clk0;
      irq_ff <= nxt_irq;
      flag_ff <= nxt_flag;
    end
  end

  // ****************************************
  // Pin and control outputs
  // ****************************************
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      nxt_sbo[i] = bpm_ff[i / 4] ? shared_segment_outputs[i] : bpl_ff[i];
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bid_out_ff <= '0;
      bid_oe_ff <= '0;
      sbo_ff <= '0;
      odp_ff <= OD_PULL_OPT;
    end
    else if (ce)
    begin
      bid_out_ff <= nxt_bid_out;
      bid_oe_ff <= nxt_bid_oe;
      sbo_ff <= nxt_sbo;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign bid_out = bid_out_ff;
  assign bid_oe = bid_oe_ff;
  assign single_bit_outputs = sbo_ff;
  assign pull_en = pull_ff;
  assign od_pull_en = odp_ff;
  assign both_edge_irq = irq_ff[0];
  assign clocked_edge_irq = irq_ff[1];
  assign async_edge_irq = irq_ff[2];

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_rd_port0;
    (ce && avs_read && wait_ff && avs_address == OFF_PORT0)
      |=> !wait_ff && rdata_ff[3:0] == $past(port0_in) && rdata_ff[31:4] == 28'h0;
  endproperty
  a_rd_port0: assert property (p_rd_port0) else $error("port 0 read mismatch");

  property p_nib_dir;
    bid_oe_ff[3:0] inside {4'h0, 4'hf} && bid_oe_ff[23:20] inside {4'h0, 4'hf};
  endproperty
  a_nib_dir: assert property (p_nib_dir) else $error("nibble port split direction");

  property p_both;
    (ce && (e_rise[0] || e_fall[0])) |=> both_edge_irq;
  endproperty
  a_both: assert property (p_both) else $error("both-edge request missing");

  property p_clk;
    (ce && clk_ev) ##1 ce |=> clocked_edge_irq && flag_ff[1];
  endproperty
  a_clk: assert property (p_clk) else $error("clocked request missing");

  property p_rise;
    (ce && e_rise[3]) |=> flag_ff[3];
  endproperty
  a_rise: assert property (p_rise) else $error("rising test flag missing");

  property p_key;
    (ce && |e_fall[11:4]) |=> flag_ff[4];
  endproperty
  a_key: assert property (p_key) else $error("key flag missing");

  property p_filt;
    ($changed(filt[0]) && $past(ce) && $past(ce, 2)) |-> $past(port1_in[0], 2) == filt[0];
  endproperty
  a_filt: assert property (p_filt) else $error("filter passed short pulse");

  property p_pair;
    (wr_go && avs_byteenable[0] && avs_address == OFF_PAIR45)
      |=> lat_ff[IDX_P4] == $past(wd[3:0]) && lat_ff[IDX_P5] == $past(wd[7:4]);
  endproperty
  a_pair: assert property (p_pair) else $error("pair write lost a nibble");

  property p_seg;
    ($past(ce) && $past(bpm_ff[0])) |-> sbo_ff[3:0] == $past(shared_segment_outputs[3:0]);
  endproperty
  a_seg: assert property (p_seg) else $error("segment data not passed");

  c_rd: cover property (ce && avs_read && !wait_ff);
  c_clk_irq: cover property (clocked_edge_irq);
  c_key: cover property ($rose(flag_ff[4]));
endmodule // pdio_top

// *** tb/pdio_pins.sv ***
/*
  Model of the circuits outside the port pins of ports 2 to 8: pull-ups,
  outside drivers and floating lines.
  Assumes the bench drives ext_val and ext_en at the rising clock edge.
*/
`timescale 1ns/1ns
module pdio_pins (
  // Clock
  input wire logic ref_clk,
  // Drive from the block
  input wire logic [27:0] bid_out,
  input wire logic [27:0] bid_oe,
  input wire logic [6:0] pull_en,
  input wire logic [7:0] od_pull_en,
  // Drive from outside circuits
  input wire logic [27:0] ext_val,
  input wire logic [27:0] ext_en,
  // Resolved pin levels
  output logic [27:0] bid_in
);
  // ****************************************
  // Pin resolution
  // ****************************************
  logic [27:0] pull;
  logic [27:0] float_ff = 28'h0;

  // A floating line toggles every cycle, so a design that reads it cannot pass by luck.
  always_ff @(posedge ref_clk)
  begin
    float_ff <= ~float_ff;
  end

  always_comb
  begin
    pull = {{4{pull_en[6]}}, {4{pull_en[5]}}, {4{pull_en[4]}}, od_pull_en,
            {4{pull_en[3]}}, {4{pull_en[2]}}};
    for (int i = 0; i < 28; i++)
    begin
      if (bid_oe[i])
        bid_in[i] = bid_out[i];
      else if (ext_en[i])
        bid_in[i] = ext_val[i];
      else
        bid_in[i] = pull[i] | float_ff[i] & ~pull[i];
    end
  end
endmodule // pdio_pins

// *** tb/pdio_top_tb.sv ***
/*
  Self-checking bench for the port block: bus tasks, pin stimulus and checks.
  Assumes the pin model in pdio_pins and a register bus answering in one wait cycle.
*/
`timescale 1ns/1ns
module pdio_top_tb;
  import pdio_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic [AW-1:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DW-1:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [DW-1:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0] port0_in = 4'h0;
  logic [3:0] port1_in = 4'h0;
  logic sub_osc_in = 1'b0;
  logic [27:0] bid_in;
  logic [27:0] bid_out;
  logic [27:0] bid_oe;
  logic [27:0] ext_val = 28'h0;
  logic [27:0] ext_en = 28'hfff00ff;
  logic [7:0] seg = 8'h3c;
  logic [7:0] sbo;
  logic [6:0] pull_en;
  logic [7:0] od_pull_en;
  logic both_irq;
  logic clk_irq;
  logic asy_irq;
  int n_fail = 0;
  int checks_done = 0;

  always #20 ref_clk = ~ref_clk;

  pdio_top pdio_top_i (.ref_clk(ref_clk), .reset_n(reset_n), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .port0_in(port0_in), .port1_in(port1_in), .sub_osc_in(sub_osc_in),
    .bid_in(bid_in), .bid_out(bid_out), .bid_oe(bid_oe),
    .shared_segment_outputs(seg), .single_bit_outputs(sbo), .pull_en(pull_en),
    .od_pull_en(od_pull_en), .both_edge_irq(both_irq), .clocked_edge_irq(clk_irq),
    .async_edge_irq(asy_irq));

  pdio_pins pdio_pins_i (.ref_clk(ref_clk), .bid_out(bid_out), .bid_oe(bid_oe),
    .pull_en(pull_en), .od_pull_en(od_pull_en), .ext_val(ext_val), .ext_en(ext_en),
    .bid_in(bid_in));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  // The request stays up until the edge that sees waitrequest low.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int i;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    for (i = 0; i < 50; i++)
    begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 50)
    begin
      n_fail++;
      $display("unexpected bus answer: expected waitrequest low, seen none");
      tally_and_finish;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(n, e, q);
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Watches one request line for a bounded number of cycles.
  task automatic pulse(input string n, input int sel, input logic e, input int bound);
    logic hit = 1'b0;
    repeat (bound)
    begin
      @(negedge ref_clk);
      if ((sel == 0 && both_irq === 1'b1) || (sel == 1 && clk_irq === 1'b1) ||
          (sel == 2 && asy_irq === 1'b1))
        hit = 1'b1;
    end
    chk(n, {31'h0, e}, {31'h0, hit});
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    tick(1);
    chk("oe after reset", 32'h0, {4'h0, bid_oe});
    chk("pull after reset", 32'h0, {25'h0, pull_en});
    chk("od pull option", {24'h0, OD_PULL_OPT}, {24'h0, od_pull_en});
    chk("od pins released", 32'hff, {24'h0, bid_in[15:8]});
    rdc("dir reset", OFF_DIR, 32'h0);
    rdc("unmapped", 8'hfc, 32'h0);
    port0_in <= 4'he;
    port1_in <= 4'h8;
    wr(OFF_PORT0, 32'h1);
    rdc("port0 pins", OFF_PORT0, 32'he);
    rdc("port1 pins", OFF_PORT1, 32'h8);
    port0_in <= 4'h0;
    port1_in <= 4'h0;
    ext_val[7:4] <= 4'hc;
    wr(8'h20, 32'h9);
    wr(OFF_DIR, 32'h1ff5);
    wr(8'h0c, 32'h3);
    tick(2);
    chk("oe low ports", 32'h5f, {24'h0, bid_oe[7:0]});
    chk("oe high ports", 32'hfff, {20'h0, bid_oe[27:16]});
    chk("port8 latch", 32'h9, {28'h0, bid_out[27:24]});
    rdc("port3 mixed", 8'h0c, 32'h9);
    wr(OFF_PAIR67, 32'h5a);
    wr(OFF_PAIR45, 32'h3c);
    tick(2);
    chk("pair67 pins", 32'h5a, {24'h0, bid_out[23:16]});
    chk("pair45 oe", 32'hc3, {24'h0, bid_oe[15:8]});
    chk("pair45 pins", 32'h3c, {24'h0, bid_in[15:8]});
    rdc("pair67 read", OFF_PAIR67, 32'h5a);
    rdc("pair45 read", OFF_PAIR45, 32'h3c);
    wr(OFF_PULL, 32'h7f);
    tick(2);
    chk("pull on", 32'h7f, {25'h0, pull_en});
    wr(OFF_PULL, 32'h0);
    wr(OFF_BITPORT, 32'h0f05);
    wr(OFF_BITPORT, 32'hf0a0);
    tick(2);
    chk("bit port", 32'ha5, {24'h0, sbo});
    wr(OFF_BPMODE, 32'h1);
    tick(2);
    chk("bit port segment", 32'hac, {24'h0, sbo});
    wr(OFF_DIR, 32'h0);
    ext_en <= 28'hfffffff;
    ext_val <= 28'h0;
    tick(4);
    wr(OFF_STAT, 32'h1f);
    rdc("stat clear", OFF_STAT, 32'h0);
    @(posedge ref_clk);
    port0_in[0] <= 1'b1;
    pulse("rise both", 0, 1'b1, 10);
    @(posedge ref_clk);
    port0_in[0] <= 1'b0;
    pulse("fall both", 0, 1'b1, 10);
    @(posedge ref_clk);
    ce <= 1'b0;
    port0_in[0] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    port0_in[0] <= 1'b0;
    repeat (2) @(posedge ref_clk);
    ce <= 1'b1;
    pulse("frozen pulse", 0, 1'b0, 10);
    @(posedge ref_clk);
    port1_in[0] <= 1'b1;
    pulse("clocked rise", 1, 1'b1, 20);
    @(posedge ref_clk);
    port1_in[1] <= 1'b1;
    repeat (3) @(posedge ref_clk);
    port1_in[1] <= 1'b0;
    pulse("glitch", 2, 1'b0, 20);
    wr(OFF_EDGE, 32'h0);
    @(posedge ref_clk);
    port1_in[1] <= 1'b1;
    pulse("direct rise off", 2, 1'b0, 15);
    @(posedge ref_clk);
    port1_in[1] <= 1'b0;
    pulse("direct fall", 2, 1'b1, 20);
    @(posedge ref_clk);
    port1_in[2] <= 1'b1;
    ext_val[21] <= 1'b1;
    sub_osc_in <= 1'b1;
    tick(12);
    @(posedge ref_clk);
    ext_val[21] <= 1'b0;
    tick(4);
    rdc("stat flags", OFF_STAT, 32'h3f);
    wr(OFF_STAT, 32'h1f);
    rdc("stat cleared", OFF_STAT, 32'h20);
    tally_and_finish;
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    $display("unexpected run length: expected end, seen limit");
    tally_and_finish;
  end
endmodule // pdio_top_tb
